// file: rtl/ctiu_top.sv
// counter/timer unit with four channels, prescaler and priority interrupt controller
// assumes a classic wishbone master on clk_i and synchronous control inputs
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "ctiu_regs.svh"
module ctiu_top import ctiu_pkg::*; (
    // clock, reset, clock enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // channel controls from the peripheral_logic_array
    input  wire logic [3:0]  en_arr_i,
    input  wire logic [3:0]  dis_arr_i,
    input  wire logic [3:0]  trg_arr_i,
    // channel controls from pins
    input  wire logic [3:0]  en_pin_i,
    input  wire logic [3:0]  dis_pin_i,
    input  wire logic [3:0]  trg_pin_i,
    // user interrupt requests from the peripheral_logic_array
    input  wire logic [3:0]  int_arr_i,
    // interrupt and timer outputs
    output logic             int_req_o,
    output logic      [2:0]  int_vec_o,
    output logic      [3:0]  tmr_out_o
);
    // bus state
    logic        ack_ff, nxt_ack;        // acknowledge
    logic [31:0] rdat_ff, nxt_rdat;      // read data
    logic        take;                   // request taken this edge
    logic        wtake;                  // write taken
    logic        vtake;                  // vector read taken
    logic        in_ch;                  // address in channel window
    logic [1:0]  ch;                     // addressed channel
    logic [15:0] psc_wr;                 // written ratio before clamping
    // configuration registers
    logic [8:0]  psc_ff, nxt_psc;        // prescale ratio
    logic [7:0]  mask_ff, nxt_mask;      // source enables
    logic [7:0]  edge_ff, nxt_edge;      // 1 = edge sensitive
    logic [5:0]  ctrl_ff [4];            // channel control words
    logic [5:0]  nxt_ctrl [4];
    logic [15:0] rld_ff [4];             // channel reload values
    logic [15:0] nxt_rld [4];
    logic [3:0]  ld_ff, nxt_ld;          // channel load pulses
    // prescaler
    logic [8:0]  pcnt_ff, nxt_pcnt;      // divider count
    logic        tick_ff, nxt_tick;      // one pulse per ratio
    // interrupt controller
    logic [7:0]  src;                    // raw sources
    logic [7:0]  sprv_ff, nxt_sprv;      // previous sources
    logic [7:0]  pend_ff, nxt_pend;      // latched edge requests
    logic [7:0]  rise;                   // source rising edges
    logic [7:0]  set_v;                  // edges that latch
    logic [7:0]  req;                    // active unmasked requests
    logic [7:0]  clr;                    // serviced source
    logic [3:0]  pv;                     // valid and vector
    logic        irq_ff;                 // request out
    logic [2:0]  vec_ff;                 // vector out
    // channel wires
    logic [15:0] cnt_w [4];              // counts
    logic [15:0] capt_w [4];             // captures
    logic [3:0]  tc_w;                   // terminal counts
    logic [3:0]  en_w, dis_w, trg_w;     // selected controls

    // byte-lane merge of a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // highest priority request, index 0 first
    function automatic logic [3:0] prio(input logic [7:0] r);
        prio = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (r[i]) begin
                prio = {1'b1, 3'(i)};
            end
        end
    endfunction : prio

    // source select per channel
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            en_w[n]  = ctrl_ff[n][`CTIU_CF_PIN] ? en_pin_i[n]  : en_arr_i[n];
            dis_w[n] = ctrl_ff[n][`CTIU_CF_PIN] ? dis_pin_i[n] : dis_arr_i[n];
            trg_w[n] = ctrl_ff[n][`CTIU_CF_PIN] ? trg_pin_i[n] : trg_arr_i[n];
        end
    end

    // interrupt request logic
    always_comb begin
        src      = {tc_w, int_arr_i};
        rise     = src & ~sprv_ff;
        set_v    = edge_ff & rise;
        req      = mask_ff & ((edge_ff & pend_ff) | (~edge_ff & src));
        pv       = prio(req);
        clr      = (vtake && pv[`CTIU_VEC_VLD]) ? (8'h01 << pv[2:0]) : 8'h00;
        nxt_pend = (pend_ff & ~clr) | set_v;
        nxt_sprv = src;
    end

    // interrupt registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sprv_ff <= 8'h00;
            pend_ff <= 8'h00;
            irq_ff  <= 1'b0;
            vec_ff  <= 3'h0;
        end else if (ce_i) begin
            sprv_ff <= nxt_sprv;
            pend_ff <= nxt_pend;
            irq_ff  <= pv[`CTIU_VEC_VLD];
            vec_ff  <= pv[2:0];
        end
    end

    // prescaler next state
    always_comb begin
        nxt_tick = 1'b0;
        nxt_pcnt = pcnt_ff + 9'h001;
        if (pcnt_ff >= psc_ff - 9'h001) begin
            nxt_pcnt = 9'h000;
            nxt_tick = 1'b1;
        end
    end

    // prescaler registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pcnt_ff <= 9'h000;
            tick_ff <= 1'b0;
        end else if (ce_i) begin
            pcnt_ff <= nxt_pcnt;
            tick_ff <= nxt_tick;
        end
    end

    // bus decode, register writes and read data
    always_comb begin
        take     = wb_cyc_i && wb_stb_i && !ack_ff;
        wtake    = take && wb_we_i;
        vtake    = take && !wb_we_i && wb_adr_i == `CTIU_A_VEC;
        in_ch    = wb_adr_i[7:6] == `CTIU_CH_WIN;
        ch       = wb_adr_i[5:4];
        psc_wr   = merge16(16'(psc_ff), wb_dat_i, wb_sel_i);
        nxt_ack  = take;
        nxt_rdat = 32'h0000_0000;
        nxt_psc  = psc_ff;
        nxt_mask = mask_ff;
        nxt_edge = edge_ff;
        nxt_ld   = 4'h0;
        for (int n = 0; n < 4; n++) begin
            nxt_ctrl[n] = ctrl_ff[n];
            nxt_rld[n]  = rld_ff[n];
        end
        if (wtake) begin
            if (wb_adr_i == `CTIU_A_PSC) begin
                // clamp on the 16-bit written value so high bits are not lost
                if (psc_wr < 16'(`CTIU_PSC_MIN)) begin
                    nxt_psc = `CTIU_PSC_MIN;
                end else if (psc_wr > 16'(`CTIU_PSC_MAX)) begin
                    nxt_psc = `CTIU_PSC_MAX;
                end else begin
                    nxt_psc = psc_wr[8:0];
                end
            end else if (wb_adr_i == `CTIU_A_MASK && wb_sel_i[0]) begin
                nxt_mask = wb_dat_i[7:0];
            end else if (wb_adr_i == `CTIU_A_EDGE && wb_sel_i[0]) begin
                nxt_edge = wb_dat_i[7:0];
            end else if (in_ch && wb_adr_i[3:2] == `CTIU_R_CTRL && wb_sel_i[0]) begin
                nxt_ctrl[ch] = wb_dat_i[5:0];
                nxt_ld[ch]   = 1'b1;
            end else if (in_ch && wb_adr_i[3:2] == `CTIU_R_RELOAD) begin
                nxt_rld[ch] = merge16(rld_ff[ch], wb_dat_i, wb_sel_i);
            end
        end else if (take) begin
            // reads; unmapped addresses answer zero
            if (wb_adr_i == `CTIU_A_PSC) begin
                nxt_rdat = 32'(psc_ff);
            end else if (wb_adr_i == `CTIU_A_MASK) begin
                nxt_rdat = 32'(mask_ff);
            end else if (wb_adr_i == `CTIU_A_EDGE) begin
                nxt_rdat = 32'(edge_ff);
            end else if (wb_adr_i == `CTIU_A_VEC) begin
                nxt_rdat = 32'(pv);
            end else if (wb_adr_i == `CTIU_A_PEND) begin
                nxt_rdat = 32'(req);
            end else if (in_ch) begin
                case (wb_adr_i[3:2])
                    `CTIU_R_CTRL:   nxt_rdat = 32'(ctrl_ff[ch]);
                    `CTIU_R_RELOAD: nxt_rdat = 32'(rld_ff[ch]);
                    `CTIU_R_COUNT:  nxt_rdat = 32'(cnt_w[ch]);
                    `CTIU_R_CAPT:   nxt_rdat = 32'(capt_w[ch]);
                    default:        nxt_rdat = 32'h0000_0000;
                endcase
            end
        end
    end

    // bus and configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
            psc_ff  <= `CTIU_PSC_RST;
            mask_ff <= 8'h00;
            edge_ff <= 8'h00;
            ld_ff   <= 4'h0;
            for (int n = 0; n < 4; n++) begin
                ctrl_ff[n] <= `CTIU_CTRL_RST;
                rld_ff[n]  <= `CTIU_CNT_BOT;
            end
        end else if (ce_i) begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
            psc_ff  <= nxt_psc;
            mask_ff <= nxt_mask;
            edge_ff <= nxt_edge;
            ld_ff   <= nxt_ld;
            for (int n = 0; n < 4; n++) begin
                ctrl_ff[n] <= nxt_ctrl[n];
                rld_ff[n]  <= nxt_rld[n];
            end
        end
    end

    // the four channels
    for (genvar g = 0; g < 4; g++) begin : g_ch
        ctiu_channel u_ch (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .ce_i     (ce_i),
            .tick_i   (tick_ff),
            .ld_i     (ld_ff[g]),
            .ctrl_i   (ctrl_ff[g]),
            .reload_i (rld_ff[g]),
            .en_i     (en_w[g]),
            .dis_i    (dis_w[g]),
            .trg_i    (trg_w[g]),
            .count_o  (cnt_w[g]),
            .capt_o   (capt_w[g]),
            .out_o    (tmr_out_o[g]),
            .tc_o     (tc_w[g])
        );
    end

    assign wb_ack_o  = ack_ff;
    assign wb_dat_o  = rdat_ff;
    assign int_req_o = irq_ff;
    assign int_vec_o = vec_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_vec_take;
        vtake;
    endsequence

    a_psc_gap: assert property (tick_ff |=> !tick_ff [*3])
        else $error("prescaler ticks closer than four clocks");
    a_psc_range: assert property (psc_ff >= `CTIU_PSC_MIN && psc_ff <= `CTIU_PSC_MAX)
        else $error("prescale ratio out of range");
    a_mask_gate: assert property (req == 8'h00 |=> !int_req_o)
        else $error("interrupt raised with no unmasked request");
    a_level_req: assert property (|(mask_ff & ~edge_ff & src) |=> int_req_o)
        else $error("asserted level source raised no interrupt");
    a_vec_top: assert property (
        pv[`CTIU_VEC_VLD] |-> req[pv[2:0]] && (req & ((8'h01 << pv[2:0]) - 8'h01)) == 8'h00)
        else $error("vector is not the highest active source");
    a_vec_read: assert property (s_vec_take |=> wb_ack_o && wb_dat_o == 32'($past(pv)))
        else $error("vector read returned wrong data");
    a_read_clear: assert property ((s_vec_take ##0 (rise & clr) == 8'h00) |=> (pend_ff & $past(clr)) == 8'h00)
        else $error("serviced source still pending after vector read");
    a_edge_latch: assert property (|set_v |=> (pend_ff & $past(set_v)) == $past(set_v))
        else $error("edge request not latched");
endmodule : ctiu_top

// file: rtl/ctiu_regs.svh
// register offsets, field positions, reset values and limits of the counter/timer/interrupt unit
// assumes word-aligned wishbone byte addresses on an 8-bit address bus
`ifndef CTIU_REGS_SVH
`define CTIU_REGS_SVH
// global registers (byte addresses)
`define CTIU_A_PSC     8'h00
`define CTIU_A_MASK    8'h04
`define CTIU_A_EDGE    8'h08
`define CTIU_A_VEC     8'h0C
`define CTIU_A_PEND    8'h10
// channel window: 0x40 + 0x10 * channel, word index in bits 3:2
`define CTIU_CH_WIN    2'h1
`define CTIU_R_CTRL    2'h0
`define CTIU_R_RELOAD  2'h1
`define CTIU_R_COUNT   2'h2
`define CTIU_R_CAPT    2'h3
// channel control fields
`define CTIU_CF_UP     3
`define CTIU_CF_RUN    4
`define CTIU_CF_PIN    5
`define CTIU_CTRL_RST  6'h00
// prescaler ratio limits and reset
`define CTIU_PSC_MIN   9'h004
`define CTIU_PSC_MAX   9'h118
`define CTIU_PSC_RST   9'h004
// count end points and vector valid bit
`define CTIU_CNT_TOP   16'hFFFF
`define CTIU_CNT_BOT   16'h0000
`define CTIU_VEC_VLD   3
`endif

// file: rtl/ctiu_pkg.sv
// types shared by the counter/timer/interrupt unit
// assumes nothing beyond a SystemVerilog compiler
package ctiu_pkg;
    // channel operating modes, three-bit control field
    typedef enum logic [2:0] {
        CTIU_M_PULSE,
        CTIU_M_WAVE,
        CTIU_M_EVENT,
        CTIU_M_CAPT,
        CTIU_M_WDOG,
        CTIU_M_OFF
    } ctiu_mode_t;
endpackage : ctiu_pkg

// file: rtl/ctiu_channel.sv
// one 16-bit counter/timer channel with five modes
// assumes tick_i is a one-cycle prescaler pulse and control inputs are synchronous
`timescale 1ns/1ps
`include "ctiu_regs.svh"
module ctiu_channel import ctiu_pkg::*; (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // prescaled tick and software load
    input  wire logic        tick_i,
    input  wire logic        ld_i,
    input  wire logic [5:0]  ctrl_i,
    input  wire logic [15:0] reload_i,
    // selected enable, disable, trigger
    input  wire logic        en_i,
    input  wire logic        dis_i,
    input  wire logic        trg_i,
    // state out
    output logic      [15:0] count_o,
    output logic      [15:0] capt_o,
    output logic             out_o,
    output logic             tc_o
);
    logic [15:0] cnt_ff, nxt_cnt;       // count value
    logic [15:0] capt_ff, nxt_capt;     // captured count
    logic        run_ff, nxt_run;       // counting allowed
    logic        out_ff, nxt_out;       // timer output
    logic        tc_ff, nxt_tc;         // terminal count pulse
    logic [2:0]  prv_ff, nxt_prv;       // previous en/dis/trg
    ctiu_mode_t  mode;                  // decoded mode
    logic        up;                    // count direction
    logic        at_end;                // count at end point
    logic [15:0] step;                  // next count value
    logic [2:0]  rise;                  // rising edges en/dis/trg

    // next state of the channel
    always_comb begin
        mode     = ctiu_mode_t'(ctrl_i[2:0]);
        up       = ctrl_i[`CTIU_CF_UP];
        at_end   = up ? (cnt_ff == `CTIU_CNT_TOP) : (cnt_ff == `CTIU_CNT_BOT);
        step     = up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
        rise     = {en_i, dis_i, trg_i} & ~prv_ff;
        nxt_cnt  = cnt_ff;
        nxt_capt = capt_ff;
        nxt_run  = run_ff;
        nxt_out  = out_ff;
        nxt_tc   = 1'b0;
        nxt_prv  = {en_i, dis_i, trg_i};
        if (ld_i) begin
            // software load restarts from reload
            nxt_cnt = reload_i;
            nxt_run = ctrl_i[`CTIU_CF_RUN];
            nxt_out = 1'b0;
        end else begin
            // disable beats enable
            if (rise[1]) begin
                nxt_run = 1'b0;
            end else if (rise[2]) begin
                nxt_run = 1'b1;
            end
            case (mode)
                CTIU_M_PULSE: begin
                    // trigger fires a one-shot pulse
                    if (rise[0]) begin
                        nxt_cnt = reload_i;
                        nxt_run = 1'b1;
                        nxt_out = 1'b1;
                    end else if (tick_i && run_ff) begin
                        if (at_end) begin
                            nxt_tc  = 1'b1;
                            nxt_run = 1'b0;
                            nxt_out = 1'b0;
                        end else begin
                            nxt_cnt = step;
                        end
                    end
                end
                CTIU_M_WAVE: begin
                    // free running square wave
                    if (tick_i && run_ff) begin
                        if (at_end) begin
                            nxt_cnt = reload_i;
                            nxt_out = ~out_ff;
                            nxt_tc  = 1'b1;
                        end else begin
                            nxt_cnt = step;
                        end
                    end
                end
                CTIU_M_EVENT: begin
                    // trigger edges are the counted events
                    if (rise[0] && run_ff) begin
                        if (at_end) begin
                            nxt_cnt = reload_i;
                            nxt_tc  = 1'b1;
                        end else begin
                            nxt_cnt = step;
                        end
                    end
                end
                CTIU_M_CAPT: begin
                    // trigger copies the running count
                    if (rise[0]) begin
                        nxt_capt = cnt_ff;
                    end
                    if (tick_i && run_ff) begin
                        if (at_end) begin
                            nxt_cnt = reload_i;
                            nxt_tc  = 1'b1;
                        end else begin
                            nxt_cnt = step;
                        end
                    end
                end
                CTIU_M_WDOG: begin
                    // trigger kicks the watchdog; expiry latches the output
                    if (rise[0]) begin
                        nxt_cnt = reload_i;
                    end else if (tick_i && run_ff) begin
                        if (at_end) begin
                            nxt_cnt = reload_i;
                            nxt_tc  = 1'b1;
                            nxt_out = 1'b1;
                        end else begin
                            nxt_cnt = step;
                        end
                    end
                end
                default: begin
                    // unused mode codes hold the channel stopped
                    nxt_run = 1'b0;
                end
            endcase
        end
    end

    // channel registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= `CTIU_CNT_BOT;
            capt_ff <= `CTIU_CNT_BOT;
            run_ff  <= 1'b0;
            out_ff  <= 1'b0;
            tc_ff   <= 1'b0;
            prv_ff  <= 3'h7;
        end else if (ce_i) begin
            cnt_ff  <= nxt_cnt;
            capt_ff <= nxt_capt;
            run_ff  <= nxt_run;
            out_ff  <= nxt_out;
            tc_ff   <= nxt_tc;
            prv_ff  <= nxt_prv;
        end
    end

    assign count_o = cnt_ff;
    assign capt_o  = capt_ff;
    assign out_o   = out_ff;
    assign tc_o    = tc_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_pulse_end;
        mode == CTIU_M_PULSE && !ld_i && !rise[0] && tick_i && run_ff && at_end;
    endsequence

    a_wave_reload: assert property (
        mode == CTIU_M_WAVE && !ld_i && tick_i && run_ff && at_end
        |=> tc_ff && cnt_ff == $past(reload_i))
        else $error("wave mode did not reload at terminal count");
    a_pulse_end: assert property (s_pulse_end |=> tc_ff && !out_ff && !run_ff)
        else $error("pulse did not end at terminal count");
    a_count_dir: assert property (
        mode == CTIU_M_CAPT && !ld_i && tick_i && run_ff && !at_end
        |=> cnt_ff == $past(step) && !tc_ff)
        else $error("count did not step in selected direction");
    a_dis_stops: assert property (rise[1] && !ld_i && !rise[0] |=> !run_ff)
        else $error("disable edge did not stop counting");
endmodule : ctiu_channel

// file: test/ctiu_arr_model.sv
// logic array model: registers the bench's request bits onto array outputs
// assumes clk_i and rst_i shared with the unit
`timescale 1ns/1ps
module ctiu_arr_model (
    // clock, reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // bench request, array outputs
    input  wire logic [15:0] req_i,
    output logic      [15:0] arr_o
);
    // array outputs change only on clock edges, low in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) arr_o <= 16'h0000;
        else       arr_o <= req_i;
    end
endmodule : ctiu_arr_model

// file: test/tb_ctiu_top.sv
// self-checking bench for ctiu_top
// assumes a wishbone answer one cycle after the take
`timescale 1ns/1ps
module tb_ctiu_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rd, q;
    logic [15:0] req = 16'h0000, arr;
    logic [11:0] pin = 12'h000;
    logic [3:0]  sel = 4'h0, tout;
    logic        irq;
    logic [2:0]  vec;
    int bad_count = 0, n_compared = 0, cyc_n = 0;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    ctiu_arr_model ctiu_arr_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .arr_o(arr));
    ctiu_top ctiu_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
        .en_arr_i(arr[11:8]), .dis_arr_i(arr[15:12]), .trg_arr_i(arr[7:4]), .en_pin_i(pin[3:0]),
        .dis_pin_i(pin[7:4]), .trg_pin_i(pin[11:8]), .int_arr_i(arr[3:0]), .int_req_o(irq),
        .int_vec_o(vec), .tmr_out_o(tout));
    // verdict and end of run
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // one compare for all values
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk("ack pulse", 32'h0, {31'h0, ack});
    endtask : bus
    // register read judged against an expected value
    task automatic rchk(input logic [7:0] a, input string nm, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rchk
    // one-cycle array and pin request pulse
    task automatic pulse(input logic [15:0] r, input logic [11:0] p);
        @(posedge clk_i);
        req <= r;
        pin <= p;
        @(posedge clk_i);
        req <= 16'h0000;
        pin <= 12'h000;
        repeat (4) @(posedge clk_i);
    endtask : pulse
    // reset values, unmapped place
    task automatic t_reset();
        rchk(8'h00, "psc", 32'h4);
        rchk(8'h04, "mask", 32'h0);
        rchk(8'h20, "unmapped", 32'h0);
    endtask : t_reset
    // ratio clamped to 4..280, then a legal ratio
    task automatic t_psc();
        bus(1'b1, 8'h00, 32'h2);
        rchk(8'h00, "psc lo", 32'h4);
        bus(1'b1, 8'h00, 32'h200);
        rchk(8'h00, "psc hi", 32'h118);
        bus(1'b1, 8'h00, 32'h6);
        rchk(8'h00, "psc six", 32'h6);
    endtask : t_psc
    // edge sources, priority, auto clear, masked source silent
    task automatic t_edge();
        bus(1'b1, 8'h04, 32'h0F);
        bus(1'b1, 8'h08, 32'h0F);
        pulse(16'h0006, 12'h000);
        rchk(8'h0C, "vec1", 32'h9);
        rchk(8'h0C, "vec2", 32'hA);
        rchk(8'h0C, "vec3", 32'h0);
        bus(1'b1, 8'h04, 32'h07);
        pulse(16'h0008, 12'h000);
        chk("irq masked", 32'h0, {31'h0, irq});
        rchk(8'h0C, "vec masked", 32'h0);
    endtask : t_edge
    // level source follows input, not cleared by read
    task automatic t_level();
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h04, 32'h1);
        req <= 16'h0001;
        repeat (4) @(posedge clk_i);
        chk("irq lvl", 32'h1, {31'h0, irq});
        chk("vec pin", 32'h0, {29'h0, vec});
        rchk(8'h0C, "lvl1", 32'h8);
        rchk(8'h0C, "lvl2", 32'h8);
        req <= 16'h0000;
        repeat (4) @(posedge clk_i);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask : t_level
    // channel 0 wave, down from 3, terminal count as source 4
    task automatic t_wave();
        bus(1'b1, 8'h04, 32'h10);
        bus(1'b1, 8'h08, 32'h10);
        bus(1'b1, 8'h44, 32'h3);
        rchk(8'h44, "reload", 32'h3);
        bus(1'b1, 8'h40, 32'h11);
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk_i);
        chk("tc irq", 32'h1, {31'h0, irq});
        chk("wave out", 32'h1, {31'h0, tout[0]});
        rchk(8'h0C, "tc vec", 32'hC);
    endtask : t_wave
    // channel 1 capture, counting up, controlled from pins
    task automatic t_capture();
        logic [31:0] c;
        bus(1'b1, 8'h54, 32'h100);
        bus(1'b1, 8'h50, 32'h3B);
        repeat (60) @(posedge clk_i);
        pulse(16'h0000, 12'h020);
        bus(1'b0, 8'h58, 32'h0);
        c = q;
        chk("count up", 32'h1, {31'h0, c > 32'h100});
        pulse(16'h0000, 12'h200);
        rchk(8'h5C, "capture", c);
        rchk(8'h58, "stopped", c);
        pulse(16'h0000, 12'h002);
        repeat (30) @(posedge clk_i);
        bus(1'b0, 8'h58, 32'h0);
        chk("restart", 32'h1, {31'h0, q > c});
    endtask : t_capture
    // channel 2 one-shot pulse from array trigger, tc as source 6
    task automatic t_pulse();
        bus(1'b1, 8'h04, 32'h40);
        bus(1'b1, 8'h08, 32'h40);
        bus(1'b1, 8'h64, 32'h2);
        bus(1'b1, 8'h60, 32'h0);
        pulse(16'h0040, 12'h000);
        chk("pulse out", 32'h1, {31'h0, tout[2]});
        repeat (40) @(posedge clk_i);
        chk("pulse end", 32'h0, {31'h0, tout[2]});
        rchk(8'h68, "pulse cnt", 32'h0);
        rchk(8'h0C, "pulse vec", 32'hE);
    endtask : t_pulse
    // channel 3 event counting, watchdog expiry, stopped code
    task automatic t_ch3();
        bus(1'b1, 8'h74, 32'h5);
        bus(1'b1, 8'h70, 32'h12);
        pulse(16'h0080, 12'h000);
        pulse(16'h0080, 12'h000);
        rchk(8'h78, "event cnt", 32'h3);
        bus(1'b1, 8'h74, 32'h2);
        bus(1'b1, 8'h70, 32'h14);
        repeat (40) @(posedge clk_i);
        chk("wdog out", 32'h1, {31'h0, tout[3]});
        bus(1'b1, 8'h70, 32'h05);
        chk("wdog off", 32'h0, {31'h0, tout[3]});
    endtask : t_ch3
    // hang guard
    always @(posedge clk_i) if (++cyc_n > 20000) begin bad_count++; end_sim(); end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_psc();
        t_edge();
        t_level();
        t_wave();
        t_capture();
        t_pulse();
        t_ch3();
        end_sim();
    end
endmodule : tb_ctiu_top
